// [logic/ptrd_map.svh]
// register indices, field positions, reset values and masks of the pad test block
`ifndef PTRD_MAP_SVH
`define PTRD_MAP_SVH

// register indices; byte address is four times the index
`define PTRD_IDX_RB_LO 14'h0457
`define PTRD_IDX_RB_HI 14'h0458
`define PTRD_IDX_IN_MODE 14'h0459
`define PTRD_IDX_OUT_MODE 14'h045a
`define PTRD_IDX_STRAP 14'h045d
`define PTRD_IDX_TEST_CTRL 14'h0460
`define PTRD_IDX_DRIVE_LO 14'h0461
`define PTRD_IDX_DRIVE_HI 14'h0462

// reset values
`define PTRD_RST_RB_LO 16'h0000
`define PTRD_RST_RB_HI 4'h0
`define PTRD_RST_IN_MODE 16'h0000
`define PTRD_RST_OUT_MODE 16'h0000
`define PTRD_RST_STRAP 16'h0000
`define PTRD_RST_TEST_CTRL 2'h0
`define PTRD_RST_DRIVE_LO 16'h0000
`define PTRD_RST_DRIVE_HI 4'h0

// test control fields
`define PTRD_CTRL_OVERRIDE_BIT 0
`define PTRD_CTRL_DIR_BIT 1

// readback-order pad vector: bits 4 and 5 carry no pad
`define PTRD_PAD_COUNT 20
`define PTRD_PAD_MASK 20'hfffcf
`define PTRD_RB_LO_MASK 16'hffcf

// bus answers
`define PTRD_RESP_OKAY 2'h0
`define PTRD_RESP_SLVERR 2'h2

`endif

// [logic/ptrd_pkg.sv]
// types shared by the pad test readback and direction block
package ptrd_pkg;

	typedef logic [15:0] ptrd_word_t;

	typedef logic [19:0] ptrd_pad_vec_t;

	typedef logic [1:0] ptrd_resp_t;

endpackage : ptrd_pkg

// [logic/ptrd_top.sv]
// pad test readback, pad mode select and pad test drive, axi4-lite slave
`include "ptrd_map.svh"

module ptrd_top #(
	parameter int ADDR_W = 16
) (
	input wire logic clk,
	input wire logic arst_n,
	// axi4-lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pads, readback order
	input wire logic [19:0] pad_in,
	output logic [19:0] pad_out,
	output logic [19:0] pad_oe,
	// functional drive from the core
	input wire logic [19:0] func_out,
	input wire logic [19:0] func_oe,
	// pad cell mode controls, mode-register order
	output logic [15:0] pad_input_mode,
	output logic [15:0] pad_output_mode,
	// levels from the bring-up strap sampler
	input wire logic [15:0] strap_levels
);

	//////////////////////////////////////////////////////////////////////
	// parameter check

	if (ADDR_W < 16) begin : g_bad_addr_w
		$error("ptrd_top: ADDR_W must be at least 16");
	end

	//////////////////////////////////////////////////////////////////////
	// state

	ptrd_pkg::ptrd_word_t in_mode;
	ptrd_pkg::ptrd_word_t out_mode;
	ptrd_pkg::ptrd_word_t drive_lo;
	logic [3:0] drive_hi;
	logic [1:0] test_ctrl;
	ptrd_pkg::ptrd_word_t rb_lo;
	logic [3:0] rb_hi;
	ptrd_pkg::ptrd_word_t strap_vec;
	logic strap_done;

	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	ptrd_pkg::ptrd_pad_vec_t sync1;
	ptrd_pkg::ptrd_pad_vec_t sync2;
	ptrd_pkg::ptrd_pad_vec_t sync3;
	ptrd_pkg::ptrd_pad_vec_t pad_level;

	//////////////////////////////////////////////////////////////////////
	// byte-lane merge

	function automatic ptrd_pkg::ptrd_word_t ptrd_merge(
		input ptrd_pkg::ptrd_word_t old_val,
		input logic [31:0] new_val,
		input logic [3:0] strb
	);
		ptrd_pkg::ptrd_word_t res;
		res = old_val;
		if (strb[0]) begin
			res[7:0] = new_val[7:0];
		end
		if (strb[1]) begin
			res[15:8] = new_val[15:8];
		end
		return res;
	endfunction : ptrd_merge

	//////////////////////////////////////////////////////////////////////
	// pad input synchroniser, three stages

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1 <= 20'h00000;
			sync2 <= 20'h00000;
			sync3 <= 20'h00000;
		end else begin
			sync1 <= pad_in;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// a bit only moves once stages two and three agree, filtering glitches
	wire [19:0] level_agree = ~(sync2 ^ sync3);
	wire [19:0] next_pad_level = (level_agree & sync3) |
		(~level_agree & pad_level);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pad_level <= 20'h00000;
		end else begin
			pad_level <= next_pad_level;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// test control decode

	wire ovr = test_ctrl[`PTRD_CTRL_OVERRIDE_BIT];
	wire dir_in = test_ctrl[`PTRD_CTRL_DIR_BIT];
	wire rb_en = ovr & dir_in;

	//////////////////////////////////////////////////////////////////////
	// readback capture

	// outside readback mode the registers read zero rather than stale levels
	wire [15:0] next_rb_lo = rb_en ?
		(pad_level[15:0] & `PTRD_RB_LO_MASK) : 16'h0000;
	wire [3:0] next_rb_hi = rb_en ? pad_level[19:16] : 4'h0;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rb_lo <= `PTRD_RST_RB_LO;
			rb_hi <= `PTRD_RST_RB_HI;
		end else begin
			rb_lo <= next_rb_lo;
			rb_hi <= next_rb_hi;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// pad direction and drive

	// mode bit i is readback bit i below 4, i+3 above; inhibit, strap unmapped
	wire [19:0] in_mode_rb = {1'b0, in_mode[15:4], 3'b000,
		in_mode[3:0]};
	wire [19:0] out_mode_rb = {1'b0, out_mode[15:4], 3'b000,
		out_mode[3:0]};
	wire [19:0] drive_rb = {drive_hi, drive_lo};

	// input mode wins when both mode bits are set
	wire [19:0] func_sel_oe = ~in_mode_rb &
		(out_mode_rb | func_oe);
	wire [19:0] test_oe = {20{~dir_in}};
	wire [19:0] next_pad_oe = `PTRD_PAD_MASK &
		(ovr ? test_oe : func_sel_oe);
	wire [19:0] next_pad_out = `PTRD_PAD_MASK &
		(ovr ? drive_rb : func_out);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pad_oe <= 20'h00000;
			pad_out <= 20'h00000;
			pad_input_mode <= `PTRD_RST_IN_MODE;
			pad_output_mode <= `PTRD_RST_OUT_MODE;
		end else begin
			pad_oe <= next_pad_oe;
			pad_out <= next_pad_out;
			pad_input_mode <= in_mode;
			pad_output_mode <= out_mode;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// strap vector, caught once at the first edge after reset release

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_vec <= `PTRD_RST_STRAP;
			strap_done <= 1'b0;
		end else if (!strap_done) begin
			strap_vec <= strap_levels;
			strap_done <= 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// axi write channel

	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire aw_have = ~s_axi_awready;
	wire w_have = ~s_axi_wready;
	wire wr_fire = aw_have & w_have & ~s_axi_bvalid;
	wire b_done = s_axi_bvalid & s_axi_bready;

	wire [13:0] wr_idx = aw_addr[15:2];
	wire wr_up;
	if (ADDR_W > 16) begin : g_wr_up
		assign wr_up = |aw_addr[ADDR_W-1:16];
	end else begin : g_wr_noup
		assign wr_up = 1'b0;
	end

	wire wr_in_mode = ~wr_up & (wr_idx == `PTRD_IDX_IN_MODE);
	wire wr_out_mode = ~wr_up & (wr_idx == `PTRD_IDX_OUT_MODE);
	wire wr_ctrl = ~wr_up & (wr_idx == `PTRD_IDX_TEST_CTRL);
	wire wr_drv_lo = ~wr_up & (wr_idx == `PTRD_IDX_DRIVE_LO);
	wire wr_drv_hi = ~wr_up & (wr_idx == `PTRD_IDX_DRIVE_HI);
	// read-only targets take the write with no effect
	wire wr_ro = ~wr_up & ((wr_idx == `PTRD_IDX_RB_LO) |
		(wr_idx == `PTRD_IDX_RB_HI) |
		(wr_idx == `PTRD_IDX_STRAP));
	wire wr_hit = wr_in_mode | wr_out_mode | wr_ctrl | wr_drv_lo |
		wr_drv_hi | wr_ro;
	wire [1:0] next_bresp = wr_hit ? `PTRD_RESP_OKAY : `PTRD_RESP_SLVERR;

	wire [15:0] merged_drv_hi = ptrd_merge({12'h000, drive_hi},
		w_data, w_strb);
	wire [15:0] merged_ctrl = ptrd_merge({14'h0000, test_ctrl},
		w_data, w_strb);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_awready <= 1'b1;
			aw_addr <= '0;
		end else if (aw_take) begin
			s_axi_awready <= 1'b0;
			aw_addr <= s_axi_awaddr;
		end else if (b_done) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_wready <= 1'b1;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (w_take) begin
			s_axi_wready <= 1'b0;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (b_done) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PTRD_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= next_bresp;
		end else if (b_done) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			in_mode <= `PTRD_RST_IN_MODE;
			out_mode <= `PTRD_RST_OUT_MODE;
		end else if (wr_fire) begin
			if (wr_in_mode) begin
				in_mode <= ptrd_merge(in_mode, w_data, w_strb);
			end
			if (wr_out_mode) begin
				out_mode <= ptrd_merge(out_mode, w_data, w_strb);
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			drive_lo <= `PTRD_RST_DRIVE_LO;
			drive_hi <= `PTRD_RST_DRIVE_HI;
			test_ctrl <= `PTRD_RST_TEST_CTRL;
		end else if (wr_fire) begin
			if (wr_drv_lo) begin
				drive_lo <= ptrd_merge(drive_lo, w_data, w_strb) &
					`PTRD_RB_LO_MASK;
			end
			if (wr_drv_hi) begin
				drive_hi <= merged_drv_hi[3:0];
			end
			if (wr_ctrl) begin
				test_ctrl <= merged_ctrl[1:0];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// axi read channel

	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire r_done = s_axi_rvalid & s_axi_rready;
	wire [13:0] rd_idx = s_axi_araddr[15:2];
	wire rd_up;
	if (ADDR_W > 16) begin : g_rd_up
		assign rd_up = |s_axi_araddr[ADDR_W-1:16];
	end else begin : g_rd_noup
		assign rd_up = 1'b0;
	end

	wire rd_rb_lo = ~rd_up & (rd_idx == `PTRD_IDX_RB_LO);
	wire rd_rb_hi = ~rd_up & (rd_idx == `PTRD_IDX_RB_HI);
	wire rd_in_mode = ~rd_up & (rd_idx == `PTRD_IDX_IN_MODE);
	wire rd_out_mode = ~rd_up & (rd_idx == `PTRD_IDX_OUT_MODE);
	wire rd_strap = ~rd_up & (rd_idx == `PTRD_IDX_STRAP);
	wire rd_ctrl = ~rd_up & (rd_idx == `PTRD_IDX_TEST_CTRL);
	wire rd_drv_lo = ~rd_up & (rd_idx == `PTRD_IDX_DRIVE_LO);
	wire rd_drv_hi = ~rd_up & (rd_idx == `PTRD_IDX_DRIVE_HI);
	wire rd_hit = rd_rb_lo | rd_rb_hi | rd_in_mode | rd_out_mode |
		rd_strap | rd_ctrl | rd_drv_lo | rd_drv_hi;

	// one-hot selects, so an or of gated words forms the mux
	wire [15:0] rd_word = ({16{rd_rb_lo}} & rb_lo) |
		({16{rd_rb_hi}} & {12'h000, rb_hi}) |
		({16{rd_in_mode}} & in_mode) |
		({16{rd_out_mode}} & out_mode) |
		({16{rd_strap}} & strap_vec) |
		({16{rd_ctrl}} & {14'h0000, test_ctrl}) |
		({16{rd_drv_lo}} & drive_lo) |
		({16{rd_drv_hi}} & {12'h000, drive_hi});
	wire [1:0] next_rresp = rd_hit ? `PTRD_RESP_OKAY : `PTRD_RESP_SLVERR;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `PTRD_RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {16'h0000, rd_word};
			s_axi_rresp <= next_rresp;
		end else if (r_done) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : ptrd_top

// [sim/ptrd_top_properties.sv]
// bus handshake and pad output properties of the pad test block
module ptrd_props (
	input logic clk,
	input logic arst_n,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic [31:0] s_axi_rdata,
	input logic [19:0] pad_oe,
	input logic [15:0] pad_input_mode,
	input logic [15:0] pad_output_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped early");
	b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|-> ##[1:2] s_axi_rvalid) else $error("read not answered");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read changed");
	r_upper_a: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
		else $error("upper read half not zero");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while answer pending");
	oe_resv_a: assert property (pad_oe[5:4] == 2'h0)
		else $error("reserved pad enabled");
	mode_rst_a: assert property ($rose(arst_n) |->
		pad_input_mode == 16'h0 && pad_output_mode == 16'h0)
		else $error("mode outputs not clear after reset");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (pad_oe != 20'h0);
	cover property (s_axi_bvalid && !s_axi_bready);
endmodule : ptrd_props

bind ptrd_top ptrd_props ptrd_props_inst (.clk(clk), .arst_n(arst_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .pad_oe(pad_oe),
	.pad_input_mode(pad_input_mode), .pad_output_mode(pad_output_mode));

// [sim/tb.sv]
// self-checking bench for the pad test block
`include "ptrd_map.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, arst_n = 1'b0;
	logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic [15:0] awa = 16'h0, ara = 16'h0, strap = 16'hc35a;
	logic [31:0] wd = 32'h0;
	logic [3:0] strb = 4'hf;
	logic [19:0] pin = 20'ha5f3c;
	logic [19:0] foe = 20'h00000;
	logic awr, wrd, bv, arr, rv;
	logic [1:0] br, rr;
	logic [31:0] rdat;
	logic [19:0] pout, poe;
	logic [15:0] imode, omode;
	int n_mismatch = 0, samples_checked = 0;
	// cycles before the master raises bready or rready
	int ready_lag = 0;
	always #2 clk = ~clk;
	ptrd_top ptrd_top_inst (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awa),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(strb), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
		.pad_in(pin), .pad_out(pout), .pad_oe(poe), .func_out(20'h0f0f0),
		.func_oe(foe), .pad_input_mode(imode),
		.pad_output_mode(omode), .strap_levels(strap));
	////////////////////////////////////////
	task automatic end_of_test();
		$display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk
	task automatic waited(input int n);
		chk("answer in time", 32'h1, {31'h0, n < 40});
		if (n >= 40)
			end_of_test();
	endtask : waited
	task automatic wr(input logic [13:0] ix, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		@(posedge clk);
		awa <= {ix, 2'h0};
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= (ready_lag == 0);
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
			if (bv && bre) break;
			if (n + 1 >= ready_lag) bre <= 1'b1;
		end
		bre <= 1'b0;
		waited(n);
		chk("bresp", {30'h0, er}, {30'h0, br});
	endtask : wr
	task automatic rd(input logic [13:0] ix, input logic [31:0] e,
		input logic [1:0] er);
		int n;
		@(posedge clk);
		ara <= {ix, 2'h0};
		arv <= 1'b1;
		rre <= (ready_lag == 0);
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
			if (rv && rre) break;
			if (n + 1 >= ready_lag) rre <= 1'b1;
		end
		rre <= 1'b0;
		waited(n);
		chk("rdata", e, rdat);
		chk("rresp", {30'h0, er}, {30'h0, rr});
	endtask : rd
	////////////////////////////////////////
	task automatic t_reset();
		rd(`PTRD_IDX_RB_LO, 32'h0, `PTRD_RESP_OKAY);
		rd(`PTRD_IDX_RB_HI, 32'h0, `PTRD_RESP_OKAY);
		rd(`PTRD_IDX_IN_MODE, 32'h0, `PTRD_RESP_OKAY);
		rd(`PTRD_IDX_OUT_MODE, 32'h0, `PTRD_RESP_OKAY);
		$display("test reset done");
	endtask : t_reset
	task automatic t_modes();
		wr(`PTRD_IDX_IN_MODE, 32'ha5a5, `PTRD_RESP_OKAY);
		wr(`PTRD_IDX_OUT_MODE, 32'h5a5a, `PTRD_RESP_OKAY);
		strb <= 4'h2;
		wr(`PTRD_IDX_IN_MODE, 32'hffff, `PTRD_RESP_OKAY);
		strb <= 4'hf;
		rd(`PTRD_IDX_IN_MODE, 32'hffa5, `PTRD_RESP_OKAY);
		rd(`PTRD_IDX_OUT_MODE, 32'h5a5a, `PTRD_RESP_OKAY);
		chk("in mode pins", 32'hffa5, {16'h0, imode});
		chk("out mode pins", 32'h5a5a, {16'h0, omode});
		chk("pad_oe func", 32'h0028a, {12'h0, poe});
		chk("pad_out func", 32'h0f0c0, {12'h0, pout});
		// core asks for inhibit and strap pads, which have no mode bit
		foe <= 20'h80040;
		repeat (2) @(posedge clk);
		chk("pad_oe core", 32'h802ca, {12'h0, poe});
		$display("test modes done");
	endtask : t_modes
	task automatic t_drive();
		wr(`PTRD_IDX_TEST_CTRL, 32'h1, `PTRD_RESP_OKAY);
		wr(`PTRD_IDX_DRIVE_LO, 32'h1234, `PTRD_RESP_OKAY);
		wr(`PTRD_IDX_DRIVE_HI, 32'ha, `PTRD_RESP_OKAY);
		repeat (2) @(posedge clk);
		chk("pad_oe", 32'hfffcf, {12'h0, poe});
		chk("pad_out", 32'ha1204, {12'h0, pout});
		rd(`PTRD_IDX_RB_LO, 32'h0, `PTRD_RESP_OKAY);
		$display("test drive done");
	endtask : t_drive
	task automatic t_readback();
		logic [19:0] p;
		wr(`PTRD_IDX_TEST_CTRL, 32'h3, `PTRD_RESP_OKAY);
		repeat (2) @(posedge clk);
		chk("pad_oe", 32'h0, {12'h0, poe});
		for (int i = 0; i < 2; i++) begin
			p = i ? 20'h5a0c3 : 20'ha5f3c;
			pin <= p;
			repeat (8) @(posedge clk);
			rd(`PTRD_IDX_RB_LO, {16'h0, p[15:0] & `PTRD_RB_LO_MASK},
				`PTRD_RESP_OKAY);
			rd(`PTRD_IDX_RB_HI, {28'h0, p[19:16]}, `PTRD_RESP_OKAY);
		end
		// read-only places must ignore writes but still answer okay
		wr(`PTRD_IDX_RB_LO, 32'hffff, `PTRD_RESP_OKAY);
		rd(`PTRD_IDX_RB_LO, 32'h5a0c3 & 32'hffcf, `PTRD_RESP_OKAY);
		wr(`PTRD_IDX_STRAP, 32'h0, `PTRD_RESP_OKAY);
		rd(`PTRD_IDX_STRAP, {16'h0, strap}, `PTRD_RESP_OKAY);
		wr(`PTRD_IDX_TEST_CTRL, 32'h2, `PTRD_RESP_OKAY);
		rd(`PTRD_IDX_RB_LO, 32'h0, `PTRD_RESP_OKAY);
		chk("pad_oe", 32'h802ca, {12'h0, poe});
		$display("test readback done");
	endtask : t_readback
	task automatic t_unmapped();
		// late ready on both answers, so the hold rules are exercised
		ready_lag = 3;
		wr(14'h0470, 32'hffff, `PTRD_RESP_SLVERR);
		rd(14'h0470, 32'h0, `PTRD_RESP_SLVERR);
		ready_lag = 0;
		$display("test unmapped done");
	endtask : t_unmapped
	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_modes();
		t_drive();
		t_readback();
		t_unmapped();
		end_of_test();
	end
endmodule : tb
